// ===== design/msb_bus_master.sv
// status bus master: word scanner, capture fifo and apb registers
// How it works
// - the bus has 16 words of 4 bits, 64 bits in all.
// - only this master drives the word select lines and strobe.
// - data lines are active low, open collector, wired OR.
// - any party may read or assert any bit of any word.
// - the word address steps by one every 310 us.
// - the address changes only while the strobe is high.
// - data is stable at least 1 us before the strobe rises.
// - data stays stable at least 15 us after the strobe rises.
// - a pause holds the strobe high and keeps the last address.
// - status-only bits set by others never change station state.
// - the master asserts the keyed bit when the transmitter keys.
// - five listed bits are status-only, driven by the master from station flags.
// - during expansion reset the strobe is high, scanning stops.
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------
// capture fifo
// -------------------------------------------------
module msb_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wr;
        logic [PW-1:0]           rd;
        logic [PW:0]             count;
    } msb_fifo_s;
    msb_fifo_s s_reg;
    msb_fifo_s s_next;
    logic      push;
    logic      pop;

    assign in_ready  = s_reg.count != (PW+1)'(DEPTH);
    assign out_valid = s_reg.count != '0;
    assign out_data  = s_reg.mem[s_reg.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wr] = in_data;
            s_next.wr = step(s_reg.wr);
        end
        if (pop) begin
            s_next.rd = step(s_reg.rd);
        end
        if (push && !pop) begin
            s_next.count = s_reg.count + 1'b1;
        end else if (pop && !push) begin
            s_next.count = s_reg.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// -------------------------------------------------
// bus master
// -------------------------------------------------
module msb_bus_master
    import msb_pkg::*;
#(
    parameter int SLOT_CYCLES = msb_pkg::SLOT_CYC
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // station side
    input  wire logic        expansion_reset_n,
    input  wire logic        transmitter_keyed_flag,
    input  wire logic        receiver_one_open_flag,
    input  wire logic        receiver_two_open_flag,
    input  wire logic        repeater_open_flag,
    input  wire logic        access_inhibit_flag,
    output logic [63:0]      command_bits,
    // multiplexed status bus
    output logic [3:0]       word_select_lines,
    output logic             word_strobe_n,
    input  wire logic [3:0]  shared_bit_lines_n_in,
    output logic [3:0]       shared_bit_lines_n_out,
    output logic [3:0]       shared_bit_lines_n_oe
);
    import msb_pkg::*;

    localparam int CW = $clog2(SLOT_CYCLES + 1);
    localparam logic [CW-1:0] FALL_AT = CW'(SETUP_CYC);
    localparam logic [CW-1:0] RISE_AT = CW'(SLOT_CYCLES - HOLD_CYC);
    localparam logic [CW-1:0] LAST    = CW'(SLOT_CYCLES - 1);

    typedef struct packed {
        msb_phase_e         phase;
        logic [CW-1:0]      cnt;
        logic [ADDR_W-1:0]  addr;
        logic               strobe_n;
        logic               drive;
        logic [BITS-1:0]    oe;
        logic               scan;
        logic               pause;
        logic [IMG_W-1:0]   tx_img;
        logic [IMG_W-1:0]   rx_img;
        logic               push;
        logic [FIFO_W-1:0]  push_data;
    } msb_state_s;

    msb_state_s         s_reg;
    msb_state_s         s_next;
    logic               wr_en;
    logic               rd_en;
    logic               go;
    logic               start;
    logic               fifo_ready;
    logic               fifo_valid;
    logic               fifo_pop;
    logic [FIFO_W-1:0]  fifo_data;
    logic [IMG_W-1:0]   live_tx;
    logic [ADDR_W-1:0]  nxt_addr;

    // -------------------------------------------------
    // word helpers
    // -------------------------------------------------
    function automatic logic [BITS-1:0] word_of(
        input logic [IMG_W-1:0]  img,
        input logic [ADDR_W-1:0] a
    );
        word_of = img[a*BITS +: BITS];
    endfunction

    function automatic logic [IMG_W-1:0] put_word(
        input logic [IMG_W-1:0]  img,
        input logic [ADDR_W-1:0] a,
        input logic [BITS-1:0]   w
    );
        put_word = img;
        put_word[a*BITS +: BITS] = w;
    endfunction

    // status-only bits come from station state, never from software
    always_comb begin
        live_tx = s_reg.tx_img & ~STATUS_ONLY_MASK;
        live_tx[BIT_TX_KEYED] = transmitter_keyed_flag;
        live_tx[BIT_RX1_OPEN] = receiver_one_open_flag;
        live_tx[BIT_RX2_OPEN] = receiver_two_open_flag;
        live_tx[BIT_RPT_OPEN] = repeater_open_flag;
        live_tx[BIT_INHIBIT]  = access_inhibit_flag;
    end

    // -------------------------------------------------
    // apb access
    // -------------------------------------------------
    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && penable && !pwrite;
    assign pready   = 1'b1;
    assign fifo_pop = rd_en && (paddr == OFS_FIFO);

    always_comb begin
        prdata  = '0;
        pslverr = 1'b0;
        unique case (paddr)
            OFS_CTRL: begin
                prdata[CTRL_SCAN]  = s_reg.scan;
                prdata[CTRL_PAUSE] = s_reg.pause;
            end
            OFS_STATUS: begin
                prdata[ADDR_W-1:0]    = s_reg.addr;
                prdata[STAT_SCANNING] = s_reg.phase == PH_SLOT;
                prdata[STAT_EMPTY]    = !fifo_valid;
                prdata[STAT_FULL]     = !fifo_ready;
            end
            OFS_TX_LO: prdata = live_tx[31:0];
            OFS_TX_HI: prdata = live_tx[63:32];
            OFS_RX_LO: prdata = s_reg.rx_img[31:0];
            OFS_RX_HI: prdata = s_reg.rx_img[63:32];
            OFS_FIFO: begin
                prdata[FIFO_W-1:0] = fifo_data;
                prdata[FIFO_VALID] = fifo_valid;
            end
            default: pslverr = psel && penable;
        endcase
    end

    // -------------------------------------------------
    // scanner
    // -------------------------------------------------
    // pause on a full fifo so no captured word is dropped
    assign go = s_reg.scan && !s_reg.pause && fifo_ready
             && expansion_reset_n;
    assign nxt_addr = s_reg.addr + 1'b1;

    always_comb begin
        s_next      = s_reg;
        s_next.push = 1'b0;
        start       = 1'b0;
        if (wr_en && paddr == OFS_CTRL) begin
            s_next.scan  = pwdata[CTRL_SCAN];
            s_next.pause = pwdata[CTRL_PAUSE];
        end
        if (wr_en && paddr == OFS_TX_LO) begin
            s_next.tx_img[31:0] = pwdata;
        end
        if (wr_en && paddr == OFS_TX_HI) begin
            s_next.tx_img[63:32] = pwdata;
        end
        if (!expansion_reset_n) begin
            // abort at once, address held, lines released
            s_next.phase    = PH_IDLE;
            s_next.strobe_n = 1'b1;
            s_next.drive    = 1'b0;
            s_next.oe       = '0;
            s_next.cnt      = LAST;
        end else begin
            unique case (s_reg.phase)
                PH_IDLE: begin
                    start = go;
                end
                PH_SLOT: begin
                    s_next.cnt = s_reg.cnt + 1'b1;
                    if (s_reg.cnt == FALL_AT - 1'b1) begin
                        s_next.strobe_n = 1'b0;
                    end
                    if (s_reg.cnt == RISE_AT - 1'b1) begin
                        s_next.strobe_n = 1'b1;
                        s_next.rx_img = put_word(s_reg.rx_img,
                            s_reg.addr, ~shared_bit_lines_n_in);
                        s_next.push = 1'b1;
                        s_next.push_data = {s_reg.addr,
                            ~shared_bit_lines_n_in};
                    end
                    if (s_reg.cnt == LAST) begin
                        start = go;
                        if (!go) begin
                            // halt: strobe stays high, address kept
                            s_next.phase = PH_IDLE;
                            s_next.drive = 1'b0;
                            s_next.oe    = '0;
                            s_next.cnt   = LAST;
                        end
                    end
                end
            endcase
        end
        if (start) begin
            // word frozen for the whole slot
            s_next.phase = PH_SLOT;
            s_next.cnt   = '0;
            s_next.addr  = nxt_addr;
            s_next.drive = 1'b1;
            s_next.oe    = word_of(live_tx, nxt_addr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg          <= '0;
            s_reg.phase    <= PH_IDLE;
            s_reg.cnt      <= LAST;
            s_reg.addr     <= 4'hF;
            s_reg.strobe_n <= 1'b1;
            s_reg.scan     <= CTRL_SCAN_RST;
            s_reg.pause    <= CTRL_PAUSE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    msb_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (s_reg.push),
        .in_ready  (fifo_ready),
        .in_data   (s_reg.push_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // -------------------------------------------------
    // pins
    // -------------------------------------------------
    assign word_select_lines      = s_reg.addr;
    assign word_strobe_n          = s_reg.strobe_n;
    assign shared_bit_lines_n_out = '0;
    assign shared_bit_lines_n_oe  = s_reg.oe;
    assign command_bits = s_reg.rx_img & ~STATUS_ONLY_MASK;

    // -------------------------------------------------
    // checks
    // -------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_slot_start;
        s_reg.phase == PH_SLOT && s_reg.cnt == '0;
    endsequence

    sequence s_strobe_rise;
        $rose(word_strobe_n) && s_reg.drive;
    endsequence

    a_addr_strobe_high: assert property (
        $changed(word_select_lines) |->
            word_strobe_n && $past(word_strobe_n))
        else $error("address moved with strobe low");

    a_addr_step_wrap: assert property (
        $changed(word_select_lines) |->
            word_select_lines == $past(word_select_lines) + 4'h1)
        else $error("address did not step by one");

    a_slot_period: assert property (
        $changed(word_select_lines) |-> $past(s_reg.cnt) == LAST)
        else $error("address step off the slot period");

    a_strobe_fall_time: assert property (
        $fell(word_strobe_n) |-> s_reg.cnt == FALL_AT && s_reg.drive)
        else $error("strobe fell at the wrong count");

    a_hold_after_rise: assert property (
        s_strobe_rise |-> s_reg.cnt == RISE_AT)
        else $error("strobe rose without full hold room");

    a_data_stable: assert property (
        s_reg.drive && $past(s_reg.drive) && s_reg.cnt != '0
            |-> $stable(shared_bit_lines_n_oe))
        else $error("driven data changed inside a slot");

    a_reset_quiet: assert property (
        !expansion_reset_n |=> word_strobe_n
            && shared_bit_lines_n_oe == '0
            && $stable(word_select_lines))
        else $error("bus active during expansion reset");

    a_release_idle: assert property (
        !s_reg.drive |-> shared_bit_lines_n_oe == '0)
        else $error("data line driven outside a slot");

    a_status_masked: assert property (
        (command_bits & STATUS_ONLY_MASK) == '0)
        else $error("status-only bit reached station state");

    a_keyed_drive: assert property (
        s_slot_start and (word_select_lines == WORD_TX_KEYED)
            |-> shared_bit_lines_n_oe[2] == $past(transmitter_keyed_flag))
        else $error("keyed bit not driven from transmitter");

    a_capture_rise: assert property (
        s_reg.push |-> $rose(word_strobe_n)
            && s_reg.push_data == {word_select_lines,
                                   ~$past(shared_bit_lines_n_in)})
        else $error("capture not at strobe rise");
endmodule

`default_nettype wire

// ===== inc/msb_pkg.sv
// constants shared by the status bus master
package msb_pkg;
    // -------------------------------------------------
    // timing
    // -------------------------------------------------
    localparam int CLK_MHZ   = 200;
    localparam int SLOT_US   = 310;
    localparam int SETUP_US  = 1;
    localparam int HOLD_US   = 15;
    localparam int SLOT_CYC  = SLOT_US * CLK_MHZ;
    localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
    localparam int HOLD_CYC  = HOLD_US * CLK_MHZ;
    // -------------------------------------------------
    // bus shape
    // -------------------------------------------------
    localparam int WORDS  = 16;
    localparam int BITS   = 4;
    localparam int ADDR_W = 4;
    localparam int IMG_W  = WORDS * BITS;
    // -------------------------------------------------
    // registers (byte addresses)
    // -------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_TX_LO  = 8'h08;
    localparam logic [7:0] OFS_TX_HI  = 8'h0C;
    localparam logic [7:0] OFS_RX_LO  = 8'h10;
    localparam logic [7:0] OFS_RX_HI  = 8'h14;
    localparam logic [7:0] OFS_FIFO   = 8'h18;
    localparam int CTRL_SCAN    = 0;
    localparam int CTRL_PAUSE   = 1;
    localparam logic CTRL_SCAN_RST  = 1'h1;
    localparam logic CTRL_PAUSE_RST = 1'h0;
    localparam int STAT_SCANNING = 4;
    localparam int STAT_EMPTY    = 5;
    localparam int STAT_FULL     = 6;
    localparam int FIFO_VALID    = 8;
    // -------------------------------------------------
    // status-only bit positions (word * 4 + bit)
    // -------------------------------------------------
    localparam int BIT_TX_KEYED  = 10;
    localparam int BIT_RX1_OPEN  = 12;
    localparam int BIT_RX2_OPEN  = 16;
    localparam int BIT_RPT_OPEN  = 20;
    localparam int BIT_INHIBIT   = 27;
    localparam logic [63:0] STATUS_ONLY_MASK = 64'h0000_0000_0811_1400;
    localparam logic [3:0]  WORD_TX_KEYED   = 4'h2;
    // -------------------------------------------------
    // capture fifo and scanner phase
    // -------------------------------------------------
    localparam int FIFO_W     = 8;
    localparam int FIFO_DEPTH = 32;
    typedef enum logic [0:0] {PH_IDLE, PH_SLOT} msb_phase_e;
endpackage

// ===== verif/msb_expansion_model.sv
// expansion module model that shares the multiplexed status bus
`timescale 1ns/1ps
`default_nettype none
module msb_expansion_model (
    // bus as seen at the connector
    input  wire logic        expansion_reset_n,
    input  wire logic [3:0]  word_select_lines,
    input  wire logic        word_strobe_n,
    input  wire logic [3:0]  shared_bit_lines_n,
    // bits this module asserts and what it read back
    input  wire logic [63:0] pattern,
    output logic [3:0]       pull_low,
    output logic [63:0]      seen
);
    // -------------------------------------------------
    // drive side
    // -------------------------------------------------
    // select and strobe are only watched here
    // pulls only its own asserted bits, released otherwise and in reset
    // held while the address stands, which covers setup and hold
    assign pull_low = expansion_reset_n ? pattern[word_select_lines*4 +: 4] : 4'h0;
    // -------------------------------------------------
    // receive side
    // -------------------------------------------------
    // lines are only trusted at a strobe rise, never during a halt
    initial seen = 64'h0;
    always @(posedge word_strobe_n) begin
        if (expansion_reset_n) begin
            seen[word_select_lines*4 +: 4] <= ~shared_bit_lines_n;
        end
    end
endmodule
`default_nettype wire

// ===== verif/multiplexed_status_bus_master_tb.sv
// self-checking bench for the status bus master with one expansion module
`timescale 1ns/1ps
`default_nettype none
module multiplexed_status_bus_master_tb;
    import msb_pkg::*;
    // slot three cycles above the fixed setup and hold counts, keeps the run short
    localparam int SLOT  = 3203;
    localparam int LIMIT = 140000;
    // -------------------------------------------------
    // signals
    // -------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, lfsr;
    logic        expansion_reset_n, word_strobe_n, last_s;
    logic [4:0]  flags;
    logic [63:0] command_bits, tx, pat, eff, img, seen;
    logic [3:0]  word_select_lines, line_n, dut_oe, dut_out, mod_oe, last_a, last_oe, exp_a;
    int          errors, comparisons, cyc, rises, since_chg, since_rise, gap, r;
    bit          gap_on;

    // pull-up on every line; any enabled driver pulls it low
    assign line_n = ~((dut_oe & ~dut_out) | mod_oe);

    msb_bus_master #(.SLOT_CYCLES(SLOT)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .expansion_reset_n(expansion_reset_n),
        .transmitter_keyed_flag(flags[0]), .receiver_one_open_flag(flags[1]),
        .receiver_two_open_flag(flags[2]), .repeater_open_flag(flags[3]),
        .access_inhibit_flag(flags[4]), .command_bits(command_bits),
        .word_select_lines(word_select_lines), .word_strobe_n(word_strobe_n),
        .shared_bit_lines_n_in(line_n), .shared_bit_lines_n_out(dut_out),
        .shared_bit_lines_n_oe(dut_oe));

    msb_expansion_model partner (
        .expansion_reset_n(expansion_reset_n), .word_select_lines(word_select_lines),
        .word_strobe_n(word_strobe_n), .shared_bit_lines_n(line_n),
        .pattern(pat), .pull_low(mod_oe), .seen(seen));
    // -------------------------------------------------
    // helpers
    // -------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ ({32{s[31]}} & 32'h0040_0007);
    endfunction

    // status-only places carry the station inputs, never software values
    function automatic logic [63:0] eff_img(input logic [63:0] t, input logic [4:0] f);
        logic [63:0] e;
        e = t & ~STATUS_ONLY_MASK;
        e[BIT_TX_KEYED] = f[0];
        e[BIT_RX1_OPEN] = f[1];
        e[BIT_RX2_OPEN] = f[2];
        e[BIT_RPT_OPEN] = f[3];
        e[BIT_INHIBIT]  = f[4];
        return e;
    endfunction

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // called just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // -------------------------------------------------
    // clock, timeout and bus monitor
    // -------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            errors++;
            $display("mismatch timeout expected %0d seen %0d", rises, cyc);
            tally_and_finish;
        end
    end

    // sampled mid-cycle so every registered output has settled
    always @(negedge pclk) begin
        if (presetn) begin
            since_chg++;
            since_rise++;
            gap++;
            if (word_select_lines !== last_a || dut_oe !== last_oe) begin
                chk("strobe at change", 1, word_strobe_n);
                chk("hold after rise", 1, 64'(since_rise >= HOLD_CYC));
                since_chg = 0;
            end
            if (word_strobe_n === 1'b1 && last_s === 1'b0 && expansion_reset_n === 1'b1) begin
                chk("setup before rise", 1, 64'(since_chg >= SETUP_CYC));
                if (gap_on && rises > 0) begin
                    chk("slot length", SLOT, gap);
                end
                chk("word address", exp_a, word_select_lines);
                chk("driven word", eff[exp_a*4 +: 4], dut_oe);
                exp_a++;
                rises++;
                gap = 0;
                since_rise = 0;
            end
            last_a = word_select_lines;
            last_oe = dut_oe;
            last_s = word_strobe_n;
        end
    end
    // -------------------------------------------------
    // main sequence
    // -------------------------------------------------
    initial begin
        lfsr = 32'h5;
        lfsr = lfsr_next(lfsr);
        tx[31:0] = lfsr;
        lfsr = lfsr_next(lfsr);
        tx[63:32] = lfsr;
        lfsr = lfsr_next(lfsr);
        pat = {lfsr, lfsr_next(lfsr)} | STATUS_ONLY_MASK;
        flags = {lfsr[4:1], 1'b1};
        eff = eff_img(tx, flags);
        img = eff | pat;
        {presetn, psel, penable, pwrite, expansion_reset_n} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        since_rise = 1000000;
        gap_on = 1'b1;
        exp_a = 4'h0;
        {last_a, last_oe, last_s} = 9'h1E1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk("reset address", 4'hF, word_select_lines);
        chk("reset lines", 5'h10, {word_strobe_n, dut_oe});
        chk("reset image", 0, command_bits);
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("control reset", 32'h1, rd);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status reset", 32'h2F, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 1, err);
        apb(1'b1, OFS_TX_LO, tx[31:0]);
        apb(1'b1, OFS_TX_HI, tx[63:32]);
        apb(1'b0, OFS_TX_LO, 32'h0);
        chk("tx readback", eff[31:0], rd);
        repeat (100) @(posedge pclk);
        chk("strobe held in reset", 5'h1F, {word_strobe_n, word_select_lines});
        $display("test setup done");
        expansion_reset_n <= 1'b1;
        while (rises < 32) @(posedge pclk);
        // a full slot, so a scanner that failed to halt would show a rise
        repeat (SLOT) @(posedge pclk);
        chk("full fifo halts scan", 32, rises);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("fifo full", 1, rd[STAT_FULL]);
        chk("halted", 0, rd[STAT_SCANNING]);
        chk("command image", img & ~STATUS_ONLY_MASK, command_bits);
        chk("module view", img, seen);
        apb(1'b0, OFS_RX_LO, 32'h0);
        chk("rx low", img[31:0], rd);
        apb(1'b0, OFS_RX_HI, 32'h0);
        chk("rx high", img[63:32], rd);
        $display("test scan done");
        gap_on = 1'b0;
        for (int i = 0; i < 32; i++) begin
            apb(1'b0, OFS_FIFO, 32'h0);
            chk("fifo entry", {1'b1, 4'(i), img[(i % 16)*4 +: 4]}, rd[8:0]);
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("fifo empty", 1, rd[STAT_EMPTY]);
        apb(1'b0, OFS_FIFO, 32'h0);
        chk("empty pop", 0, rd[FIFO_VALID]);
        $display("test drain done");
        apb(1'b1, OFS_CTRL, 32'h3);
        repeat (SLOT) @(posedge pclk);
        r = rises;
        repeat (1000) @(posedge pclk);
        chk("pause rises", r, rises);
        chk("pause address", 4'(exp_a - 1), word_select_lines);
        chk("pause strobe", 1, word_strobe_n);
        apb(1'b1, OFS_CTRL, 32'h1);
        // abort the resumed slot while its strobe is low, before capture
        while (word_strobe_n !== 1'b0) @(posedge pclk);
        $display("test pause done");
        expansion_reset_n <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        chk("abort lines", 5'h10, {word_strobe_n, dut_oe});
        exp_a = exp_a + 4'h1;
        r = rises;
        repeat (50) @(posedge pclk);
        expansion_reset_n <= 1'b1;
        while (rises == r) @(posedge pclk);
        $display("test abort done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
